// ### design/mia_ack.sv
// Maskable interrupt acknowledge, nesting control and entry sequencing
`timescale 1ns/1ns
module mia_ack
   import mia_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Peripheral requests and configuration
   input wire logic [NUM_SRC-1:0] req_set,
   input wire mia_src_cfg_t [NUM_SRC-1:0] src_cfg,
   input wire logic [VEC_W-1:0] vec_table [NUM_SRC],
   // Core status and control
   input wire logic global_irq_enable,
   input wire logic lowest_level_nest_block,
   input wire logic core_ready,
   input wire logic vectored_return_op,
   input wire logic bank_switch_return_op,
   input wire logic pin_nmi_take,
   input wire logic watchdog_nmi_take,
   // Macro service counter load
   input wire logic msc_load,
   input wire logic [SRC_W-1:0] msc_load_src,
   input wire logic [MSC_W-1:0] msc_load_val,
   // Entry command and state
   output mia_accept_t accept,
   output logic clear_global_enable,
   output logic [NUM_SRC-1:0] req_pending,
   output logic [ISR_W-1:0] in_service_level_reg,
   output logic lowest_level_in_service_bit,
   output logic pin_nmi_in_service,
   output logic watchdog_nmi_in_service
);
   typedef enum logic [1:0] {ST_IDLE, ST_MSC_RD, ST_MSC_UPD} mia_st_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic level_ok(input logic [1:0] lvl, input logic [ISR_W-1:0] isr,
                                     input logic nest_blk);
      logic ok;
      ok = 1'b1;
      if (isr[ISR_PIN_NMI] || isr[ISR_WDT_NMI] || isr[0]) begin
         ok = 1'b0; // [R16]
      end else if (isr[1]) begin
         ok = (lvl == 2'd0); // [R15] [R19]
      end else if (isr[2]) begin
         ok = (lvl <= 2'd1); // [R15]
      end else if (isr[ISR_LVL3]) begin
         ok = nest_blk ? (lvl <= 2'd2) : 1'b1; // [R14]
      end
      return ok;
   endfunction : level_ok

   ////////////////////////////////////////////////////////////////////////////////
   // State
   logic [NUM_SRC-1:0] flag, next_flag;
   logic [ISR_W-1:0] next_isr;
   mia_st_t st, next_st;
   logic [SRC_W-1:0] msrc, next_msrc;
   mia_accept_t next_accept;
   logic next_clear_ge;
   logic [MSC_W-1:0] msc_rd;
   logic msc_wr;
   logic [SRC_W-1:0] msc_wa;
   logic [MSC_W-1:0] msc_wd;
   // Macro count done, request now vectored
   logic [NUM_SRC-1:0] msc_done, next_msc_done;

   mia_msc_mem u_msc (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .wr_en(msc_wr),
      .wr_addr(msc_wa),
      .wr_data(msc_wd),
      .rd_addr(next_msrc),
      .rd_data(msc_rd)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Arbitration
   logic best_v, mac_v;
   logic [SRC_W-1:0] best, mac;
   logic [1:0] best_lvl;
   logic [1:0] ret_lvl;
   logic ret_any;
   always_comb begin
      best_v = 1'b0;
      best = '0;
      best_lvl = 2'd3;
      mac_v = 1'b0;
      mac = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (flag[i] && !src_cfg[i].mask) begin // [R1]
            if (src_cfg[i].macro_en && !msc_done[i]) begin
               mac_v = 1'b1; // [R2]
               mac = SRC_W'(i);
            end else if (global_irq_enable
                         && level_ok(src_cfg[i].level, in_service_level_reg,
                                     lowest_level_nest_block)
                         && (!best_v || src_cfg[i].level <= best_lvl)) begin // [R3] [R4] [R13]
               best_v = 1'b1;
               best = SRC_W'(i);
               best_lvl = src_cfg[i].level;
            end
         end
      end
      ret_any = 1'b0;
      ret_lvl = 2'd0;
      for (int l = NUM_LVL - 1; l >= 0; l--) begin
         if (in_service_level_reg[l]) begin
            ret_any = 1'b1;
            ret_lvl = 2'(l);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencing
   always_comb begin
      next_flag = flag;
      next_msc_done = msc_done;
      next_isr = in_service_level_reg;
      next_st = st;
      next_msrc = msrc;
      next_accept = '0;
      next_clear_ge = 1'b0;
      msc_wr = msc_load;
      msc_wa = msc_load_src;
      msc_wd = msc_load_val;
      if (vectored_return_op || bank_switch_return_op) begin
         if (in_service_level_reg[ISR_PIN_NMI] || in_service_level_reg[ISR_WDT_NMI]) begin
            next_isr[ISR_PIN_NMI] = 1'b0;
            next_isr[ISR_WDT_NMI] = 1'b0;
         end else if (ret_any) begin
            next_isr[ret_lvl] = 1'b0; // [R8]
         end
      end
      if (pin_nmi_take) next_isr[ISR_PIN_NMI] = 1'b1; // [R18]
      if (watchdog_nmi_take) next_isr[ISR_WDT_NMI] = 1'b1; // [R18]
      case (st)
         ST_IDLE: begin
            if (core_ready && mac_v) begin
               next_msrc = mac; // [R2]
               next_st = ST_MSC_RD;
               next_flag[mac] = 1'b0; // [R20]
            end else if (core_ready && best_v) begin // [R5]
               next_flag[best] = 1'b0; // [R20]
               next_msc_done[best] = 1'b0;
               next_isr[best_lvl] = 1'b1; // [R6]
               next_clear_ge = 1'b1; // [R6]
               next_accept.valid = 1'b1;
               next_accept.src = best;
               next_accept.level = best_lvl;
               next_accept.vec_addr = vec_table[best]; // [R6]
               next_accept.bank = vec_table[best][BANK_LSB +: BANK_W]; // [R10]
               next_accept.kind = src_cfg[best].bank_en ? MIA_BANK : MIA_VECTORED; // [R9] [R11]
            end
         end
         ST_MSC_RD: next_st = ST_MSC_UPD;
         ST_MSC_UPD: begin
            next_st = ST_IDLE;
            msc_wr = 1'b1;
            msc_wa = msrc;
            msc_wd = msc_rd - MSC_W'(1);
            next_accept.valid = 1'b1;
            next_accept.src = msrc;
            next_accept.kind = MIA_MACRO; // [R17]
            if (msc_rd <= MSC_W'(1)) begin
               next_flag[msrc] = 1'b1; // [R17]
               next_msc_done[msrc] = 1'b1; // [R17]
            end
         end
         default: next_st = ST_IDLE;
      endcase
      next_flag = next_flag | req_set;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         flag <= '0;
         msc_done <= '0;
         in_service_level_reg <= ISR_RESET;
         st <= ST_IDLE;
         msrc <= '0;
         accept <= '0;
         clear_global_enable <= 1'b0;
      end else begin
         flag <= next_flag;
         msc_done <= next_msc_done;
         in_service_level_reg <= next_isr;
         st <= next_st;
         msrc <= next_msrc;
         accept <= next_accept;
         clear_global_enable <= next_clear_ge;
      end
   end

   assign req_pending = flag;
   assign lowest_level_in_service_bit = in_service_level_reg[ISR_LVL3];
   assign pin_nmi_in_service = in_service_level_reg[ISR_PIN_NMI];
   assign watchdog_nmi_in_service = in_service_level_reg[ISR_WDT_NMI];

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_msc_start;
      st == ST_IDLE && core_ready && mac_v;
   endsequence
   sequence s_msc_done;
      ##3 accept.valid && accept.kind == MIA_MACRO;
   endsequence

   AST_MASKED_NO_ACCEPT: assert property (accept.valid && accept.kind != MIA_MACRO // [R1]
      |-> !$past(src_cfg[next_accept.src].mask)) else $error("Masked source accepted");
   AST_MACRO_SEQ: assert property (s_msc_start |-> s_msc_done) // [R2]
      else $error("Macro service did not run");
   AST_NEEDS_IE: assert property (accept.valid && accept.kind != MIA_MACRO // [R3]
      |-> $past(global_irq_enable)) else $error("Entry without enable");
   AST_ISR_SET: assert property (accept.valid && accept.kind != MIA_MACRO // [R6]
      |-> in_service_level_reg[accept.level] && clear_global_enable)
      else $error("Entry did not mark level");
   AST_BANK_BITS: assert property (accept.valid && accept.kind == MIA_BANK // [R10]
      |-> accept.bank == $past(vec_table[next_accept.src][BANK_LSB +: BANK_W]))
      else $error("Bad bank");
   AST_LVL0_BLOCK: assert property (in_service_level_reg[0] && st == ST_IDLE // [R16]
      |=> !(accept.valid && accept.kind != MIA_MACRO)) else $error("Nested over level0");
   AST_LVL1_ONLY0: assert property (in_service_level_reg[1:0] == 2'h2 // [R15]
      |=> !(accept.valid && accept.kind != MIA_MACRO && accept.level != 2'h0))
      else $error("Level1 nesting wrong");
   AST_LVL3_BLOCK: assert property (in_service_level_reg[3:0] == 4'h8 // [R14]
      && lowest_level_nest_block
      |=> !(accept.valid && accept.kind != MIA_MACRO && accept.level == 2'h3))
      else $error("Level3 nesting wrong");
   AST_FLAG_CLEAR: assert property (st == ST_IDLE && core_ready && !mac_v && best_v // [R20]
      && !req_set[best] |=> !flag[$past(best)]) else $error("Flag not cleared");
endmodule : mia_ack

// ### design/mia_pkg.sv
// Package of constants and types for the maskable interrupt acknowledge block
// Function
// R1: Candidate needs flag set, mask clear
// R2: Macro service accepted at once, ungated
// R3: Vectored/bank entry needs enable and level permit
// R4: Highest level wins, ties by default order
// R5: Blocked request stays pending until acceptable
// R6: Vectored entry pushes, disables, marks level, vectors
// R7: Vectored service ends with vectored return
// R8: Return clears in-service bit of its level
// R9: Bank entry only with bank enable set
// R10: Bank from three low vector-address bits; the code takes bits 3:1 (BANK_LSB 1, BANK_W 3)
// R11: Bank entry loads pc, saves pc and status
// R12: Bank service ends with bank return
// R13: Four programmable levels plus default order
// R14: Level 3 in service: block bit gates nesting
// R15: Level 2 allows 0/1, level 1 allows 0
// R16: Level 0 or nmi: macro service only
// R17: Macro service transfers, vectors after count done
// R18: Separate in-service bits for pin and watchdog nmi
// R19: Level 0 highest, bits 0..3 map levels
// R20: Accepted request flag cleared on entry
package mia_pkg;
   localparam int NUM_SRC = 25;
   localparam int SRC_W = 5;
   localparam int NUM_LVL = 4;
   localparam int ISR_W = 8;
   localparam int ISR_LVL3 = 3;
   localparam int ISR_PIN_NMI = 7;
   localparam int ISR_WDT_NMI = 6;
   localparam int BANK_W = 3;
   localparam int BANK_LSB = 1;
   localparam int MSC_W = 8;
   localparam int VEC_W = 16;
   localparam int VEC_BASE = 16'h0000;
   localparam logic [ISR_W-1:0] ISR_RESET = 8'h00;
   localparam logic [MSC_W-1:0] MSC_ZERO = 8'h00;

   // Entry kinds handed to the core
   typedef enum logic [1:0] {
      MIA_NONE, MIA_VECTORED, MIA_BANK, MIA_MACRO
   } mia_kind_t;

   // Per-source configuration
   typedef struct packed {
      logic [1:0] level;
      logic mask;
      logic macro_en;
      logic bank_en;
   } mia_src_cfg_t;

   // Acceptance command to the core
   typedef struct packed {
      logic valid;
      mia_kind_t kind;
      logic [SRC_W-1:0] src;
      logic [VEC_W-1:0] vec_addr;
      logic [BANK_W-1:0] bank;
      logic [1:0] level;
   } mia_accept_t;
endpackage : mia_pkg

// ### design/mia_msc_mem.sv
// Per-source macro service counter memory with registered read
`timescale 1ns/1ns
module mia_msc_mem
   import mia_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Write port
   input wire logic wr_en,
   input wire logic [SRC_W-1:0] wr_addr,
   input wire logic [MSC_W-1:0] wr_data,
   // Read port
   input wire logic [SRC_W-1:0] rd_addr,
   output logic [MSC_W-1:0] rd_data
);
   logic [MSC_W-1:0] mem [NUM_SRC];
   logic [MSC_W-1:0] next_rd_data;

   always_comb begin
      next_rd_data = mem[rd_addr];
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= MSC_ZERO;
         for (int i = 0; i < NUM_SRC; i++) begin
            mem[i] <= MSC_ZERO;
         end
      end else begin
         rd_data <= next_rd_data;
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
      end
   end
endmodule : mia_msc_mem

// ### tb/mia_core_model.sv
// Core-side model: enable flag, entry readiness and return pulses
`timescale 1ns/1ns
module mia_core_model
   import mia_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Bench control
   input wire logic slow,
   input wire logic en_op,
   input wire logic ret_op,
   // From the block
   input wire mia_accept_t accept,
   input wire logic clear_global_enable,
   // To the block
   output logic global_irq_enable,
   output logic core_ready,
   output logic vectored_return_op,
   output logic bank_switch_return_op
);
   logic [1:0] cnt;
   logic last_bank;
   // Slow core takes an entry one cycle in four
   assign core_ready = !slow || (cnt == 2'h3);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 2'h0;
         global_irq_enable <= 1'b0;
         last_bank <= 1'b0;
         vectored_return_op <= 1'b0;
         bank_switch_return_op <= 1'b0;
      end else begin
         cnt <= cnt + 2'h1;
         if (clear_global_enable) global_irq_enable <= 1'b0;
         else if (en_op) global_irq_enable <= 1'b1;
         if (accept.valid && accept.kind != MIA_MACRO) last_bank <= (accept.kind == MIA_BANK);
         else if (ret_op) last_bank <= 1'b0;
         // Service ends with the return matching its entry
         vectored_return_op <= ret_op && !last_bank;
         bank_switch_return_op <= ret_op && last_bank;
      end
   end
endmodule : mia_core_model

// ### tb/maskable_irq_acknowledge_bench.sv
// Self-checking bench for the maskable interrupt acknowledge block
`timescale 1ns/1ns
module maskable_irq_acknowledge_bench;
   import mia_pkg::*;
   logic clk_sys = 0, reset_n = 0, nest_blk = 0, pin_nmi = 0, wdt_nmi = 0;
   logic msc_load = 0, en_op = 0, ret_op = 0, slow = 0, gie, rdy, vret, bret, cge;
   logic [NUM_SRC-1:0] req_set = '0, pend;
   mia_src_cfg_t [NUM_SRC-1:0] src_cfg = '0;
   logic [VEC_W-1:0] vec_table [NUM_SRC];
   logic [SRC_W-1:0] msc_src = '0;
   logic [MSC_W-1:0] msc_val = '0;
   mia_accept_t accept;
   logic [ISR_W-1:0] isr;
   logic low_bit, pin_bit, wdt_bit;
   int n_mismatch = 0, samples_checked = 0;
   mia_ack i_mia_ack (.clk_sys(clk_sys), .reset_n(reset_n), .req_set(req_set),
      .src_cfg(src_cfg), .vec_table(vec_table), .global_irq_enable(gie),
      .lowest_level_nest_block(nest_blk), .core_ready(rdy), .vectored_return_op(vret),
      .bank_switch_return_op(bret), .pin_nmi_take(pin_nmi), .watchdog_nmi_take(wdt_nmi),
      .msc_load(msc_load), .msc_load_src(msc_src), .msc_load_val(msc_val),
      .accept(accept), .clear_global_enable(cge), .req_pending(pend),
      .in_service_level_reg(isr), .lowest_level_in_service_bit(low_bit),
      .pin_nmi_in_service(pin_bit), .watchdog_nmi_in_service(wdt_bit));
   mia_core_model i_mia_core_model (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
      .en_op(en_op), .ret_op(ret_op), .accept(accept), .clear_global_enable(cge),
      .global_irq_enable(gie), .core_ready(rdy), .vectored_return_op(vret),
      .bank_switch_return_op(bret));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic step(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask : pulse
   task automatic raise(logic [NUM_SRC-1:0] v);
      req_set = v;
      step(1);
      req_set = '0;
   endtask : raise
   task automatic quiet(int n);
      repeat (n) begin
         step(1);
         chk(accept.valid, 0);
      end
   endtask : quiet
   // Wait for an entry and compare kind, source, level, vector, enable clear and, for bank entries, bank with the source setup
   task automatic take(mia_kind_t k, int s);
      int i;
      for (i = 0; i < 16 && accept.valid !== 1'b1; i++) step(1);
      if (i == 16) begin
         chk(0, 1);
         report_and_stop();
      end
      chk({accept.kind, accept.src, accept.level},
          {k, 5'(s), ((k == MIA_MACRO) ? 2'h0 : src_cfg[s].level)});
      chk(accept.vec_addr, (k == MIA_MACRO) ? 16'h0000 : vec_table[s]);
      chk(cge, k != MIA_MACRO);
      if (k == MIA_BANK) chk(accept.bank, vec_table[s][3:1]);
      // Let the enable clear reach the core
      step(1);
   endtask : take
   task automatic ret(logic [7:0] exp);
      pulse(ret_op);
      step(1);
      chk(isr, exp);
   endtask : ret
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_mask();
      src_cfg[5] = '{level: 2'h2, mask: 1'b1, macro_en: 1'b0, bank_en: 1'b0};
      pulse(en_op);
      raise(25'h20);
      quiet(6);
      chk(pend, 25'h20);
      src_cfg[5].mask = 1'b0;
      take(MIA_VECTORED, 5);
      chk({isr, gie}, {8'h04, 1'b0});
      step(1);
      chk(pend, 0);
      ret(8'h00);
   endtask : t_mask
   task automatic t_prio();
      src_cfg[3].level = 2'h2;
      src_cfg[9].level = 2'h1;
      src_cfg[12].level = 2'h1;
      raise(25'h1208);
      quiet(4);
      pulse(en_op);
      take(MIA_VECTORED, 9);
      pulse(en_op);
      quiet(5);
      ret(8'h00);
      take(MIA_VECTORED, 12);
      pulse(en_op);
      quiet(4);
      ret(8'h00);
      take(MIA_VECTORED, 3);
      src_cfg[1].level = 2'h0;
      pulse(en_op);
      raise(25'h2);
      take(MIA_VECTORED, 1);
      chk(isr, 8'h05);
      pulse(en_op);
      raise(25'h1000);
      quiet(5);
      ret(8'h04);
      take(MIA_VECTORED, 12);
      ret(8'h04);
      ret(8'h00);
   endtask : t_prio
   task automatic t_nest();
      src_cfg[20].level = 2'h3;
      src_cfg[21].level = 2'h3;
      nest_blk = 1'b1;
      pulse(en_op);
      raise(25'h100000);
      take(MIA_VECTORED, 20);
      chk({isr, low_bit}, {8'h08, 1'b1});
      pulse(en_op);
      raise(25'h200000);
      quiet(5);
      nest_blk = 1'b0;
      take(MIA_VECTORED, 21);
      ret(8'h00);
      ret(8'h00);
   endtask : t_nest
   task automatic t_bank_macro();
      slow = 1'b1;
      src_cfg[7].bank_en = 1'b1;
      pulse(en_op);
      raise(25'h80);
      take(MIA_BANK, 7);
      ret(8'h00);
      slow = 1'b0;
      msc_src = 5'h0f;
      msc_val = 8'h03;
      pulse(msc_load);
      src_cfg[15].macro_en = 1'b1;
      pulse(pin_nmi);
      step(1);
      chk({isr, pin_bit}, {8'h80, 1'b1});
      raise(25'h8000);
      take(MIA_MACRO, 15);
      chk(isr, 8'h80);
      raise(25'h8000);
      take(MIA_MACRO, 15);
      raise(25'h8000);
      take(MIA_MACRO, 15);
      pulse(en_op);
      quiet(3);
      chk(pend, 25'h8000);
      ret(8'h00);
      take(MIA_VECTORED, 15);
      ret(8'h00);
      pulse(wdt_nmi);
      step(1);
      chk({isr, wdt_bit}, {8'h40, 1'b1});
      ret(8'h00);
   endtask : t_bank_macro
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < NUM_SRC; i++) vec_table[i] = 16'h0200 + 16'(2 * i);
      step(5);
      reset_n = 1'b1;
      chk({accept.valid, isr, cge}, 0);
      t_mask();
      t_prio();
      t_nest();
      t_bank_macro();
      report_and_stop();
   end
endmodule : maskable_irq_acknowledge_bench
